// ==== hw/bcdu_pkg.sv ====
/*
 * Shared constants and types of the BCD arithmetic unit: register map, field layouts,
 * digit arithmetic constants, command and flag structs.
 * Assumes a 32-bit AHB-Lite register bus and 16-bit BCD words of four digits.
 */
package bcdu_pkg;

  localparam int DIGIT_W = 4;
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ADD_DIGITS = 4;
  localparam int DIV_DIGITS = 8;

  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [4:0] BCD_MAX5 = 5'h09;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic [3:0] BCD_RADIX = 4'hA;
  localparam logic [3:0] BCD_ONE = 4'h1;
  localparam logic [3:0] BCD_ZERO = 4'h0;

  localparam logic HRESP_OKAY = 1'b0;

  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OPA_LO = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OPA_HI = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OPB_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_OPB_HI = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RES0 = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RES1 = 8'h18;
  localparam logic [ADDR_W-1:0] REG_RES2 = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_RES3 = 8'h20;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h24;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h2C;

  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_DIV} bcdu_op_t;

  // Command word: bit 0 is the input condition, bits 2:1 select the operation.
  typedef struct packed {
    bcdu_op_t op;
    logic cond;
  } bcdu_cmd_t;

  // Flags word: carry, BCD error, result output, divisor zero, busy from bit 0 up.
  typedef struct packed {
    logic busy;
    logic div_zero;
    logic result;
    logic bcd_err;
    logic carry;
  } bcdu_flags_t;

  // Interrupt status and mask: done, BCD error, result output on from bit 0 up.
  typedef struct packed {
    logic result;
    logic bcd_err;
    logic done;
  } bcdu_irq_t;

  localparam int CMD_W = $bits(bcdu_cmd_t);
  localparam int FLAGS_W = $bits(bcdu_flags_t);
  localparam int IRQ_W = $bits(bcdu_irq_t);

  function automatic logic bcdu_is_bcd(input logic [DATA_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DATA_W / DIGIT_W; i++) begin
      if (v[DIGIT_W*i +: DIGIT_W] > BCD_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : bcdu_is_bcd

endpackage : bcdu_pkg

// ==== hw/bcdu_addsub.sv ====
/*
 * Ripple BCD adder or subtractor over a parameterised number of digits.
 * Assumes both operands hold valid BCD digits; purely combinational.
 */
`timescale 1ns/1ps
module bcdu_addsub #(
  parameter int DIGITS = 4
) (
  input wire logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] a,
  input wire logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] b,
  input wire logic cin,
  input wire logic sub,
  output logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] d,
  output logic cout
);
  import bcdu_pkg::*;

  logic [DIGIT_W:0] raw;
  logic c;

  // In subtract mode cin and cout are borrows; a final borrow leaves the tens complement.
  always_comb begin
    c = cin;
    raw = '0;
    d = '0;
    for (int i = 0; i < DIGITS; i++) begin
      if (sub) begin
        raw = {1'b0, a[DIGIT_W*i +: DIGIT_W]} - {1'b0, b[DIGIT_W*i +: DIGIT_W]} - {4'h0, c};
        c = raw[DIGIT_W];
        d[DIGIT_W*i +: DIGIT_W] = c ? raw[DIGIT_W-1:0] + BCD_RADIX : raw[DIGIT_W-1:0];
      end else begin
        raw = {1'b0, a[DIGIT_W*i +: DIGIT_W]} + {1'b0, b[DIGIT_W*i +: DIGIT_W]} + {4'h0, c};
        c = raw > BCD_MAX5;
        d[DIGIT_W*i +: DIGIT_W] = c ? raw[DIGIT_W-1:0] + BCD_ADJ : raw[DIGIT_W-1:0];
      end
    end
    cout = c;
  end

endmodule : bcdu_addsub

// ==== hw/bcdu_div.sv ====
/*
 * Sequential BCD long divider: one quotient digit per pass by repeated trial subtraction.
 * Assumes valid BCD operands and a non-zero divisor; start is ignored while busy.
 */
`timescale 1ns/1ps
module bcdu_div #(
  parameter int DIGITS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] dividend,
  input wire logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] quotient,
  output logic [bcdu_pkg::DIGIT_W*DIGITS-1:0] remainder
);
  import bcdu_pkg::*;

  localparam int W = DIGIT_W * DIGITS;
  localparam int CW = $clog2(DIGITS);

  typedef enum logic [1:0] {DV_IDLE, DV_SHIFT, DV_SUB} bcdu_dv_state_t;

  bcdu_dv_state_t state;
  logic [W-1:0] dvd;
  logic [W-1:0] dsr;
  logic [W+DIGIT_W-1:0] part;
  logic [W+DIGIT_W-1:0] diff;
  logic [DIGIT_W-1:0] qd;
  logic [CW-1:0] cnt;
  logic borrow;

  // The partial remainder stays below ten divisors, so one extra digit is enough.
  bcdu_addsub #(.DIGITS(DIGITS + 1)) u_trial (
    .a(part),
    .b({BCD_ZERO, dsr}),
    .cin(1'b0),
    .sub(1'b1),
    .d(diff),
    .cout(borrow)
  );

  assign busy = state != DV_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= DV_IDLE;
      dvd <= '0;
      dsr <= '0;
      part <= '0;
      qd <= '0;
      cnt <= '0;
      done <= 1'b0;
      quotient <= '0;
      remainder <= '0;
    end else begin
      done <= 1'b0;
      unique case (state)
        DV_IDLE: begin
          if (start) begin
            dvd <= dividend;
            dsr <= divisor;
            part <= '0;
            cnt <= '0;
            state <= DV_SHIFT;
          end
        end
        DV_SHIFT: begin
          part <= {part[W-1:0], dvd[W-1 -: DIGIT_W]};
          dvd <= dvd << DIGIT_W;
          qd <= '0;
          state <= DV_SUB;
        end
        DV_SUB: begin
          if (!borrow) begin
            part <= diff;
            qd <= qd + BCD_ONE;
          end else begin
            quotient <= {quotient[W-DIGIT_W-1:0], qd};
            if (cnt == CW'(DIGITS - 1)) begin
              remainder <= part[W-1:0];
              done <= 1'b1;
              state <= DV_IDLE;
            end else begin
              cnt <= cnt + 1'b1;
              state <= DV_SHIFT;
            end
          end
        end
        default: state <= DV_IDLE;
      endcase
    end
  end

endmodule : bcdu_div

// ==== hw/bcdu_top.sv ====
/*
 * BCD arithmetic unit: 4-digit add and subtract with carry, 8-digit divide, behind an
 * AHB-Lite register slave with a sticky interrupt status.
 * Assumes a single AHB-Lite master, whole-word single transfers, and one clock hclk.
 */
`timescale 1ns/1ps
module bcdu_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [bcdu_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [bcdu_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [bcdu_pkg::DATA_W-1:0] hrdata,
  output logic hresp,
  output logic irq,
  output logic result_out
);
  import bcdu_pkg::*;

  // Bus phase tracking.
  logic accept;
  logic wr_pend;
  logic rd_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rdata;

  // Operand and result words; index 1 is the upper half of a double-length value.
  logic [1:0][WORD_W-1:0] opa;
  logic [1:0][WORD_W-1:0] opb;
  logic [3:0][WORD_W-1:0] res;

  // Flags and interrupt state.
  logic carry;
  logic bcd_err;
  logic div_zero;
  bcdu_irq_t irq_stat;
  bcdu_irq_t irq_mask;
  bcdu_irq_t irq_ev;
  bcdu_flags_t flags_r;
  bcdu_flags_t flags_w;
  bcdu_cmd_t cmd_w;

  // Command decode.
  logic go;
  logic run;
  logic is_as;
  logic is_sub;
  logic is_div;
  logic ok4;
  logic ok8;
  logic as_fire;
  logic div_start;
  logic bcd_fault;
  logic ins_done;

  // Register strobes of the data phase, shared by the register processes below.
  logic cmd_wr;
  logic flags_wr;
  logic mask_wr;
  logic stat_rd;

  // Datapath.
  logic [WORD_W-1:0] as_d;
  logic [WORD_W-1:0] abs_d;
  logic as_c;
  logic div_busy;
  logic div_done;
  logic [DATA_W-1:0] quo;
  logic [DATA_W-1:0] rmd;

  // Only the transfer bit of htrans matters: every accepted transfer is a single word.
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= '0;
      rd_addr <= '0;
    end else begin
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
      if (accept) begin
        wr_addr <= haddr[ADDR_W-1:0];
        rd_addr <= haddr[ADDR_W-1:0];
      end
    end
  end

  // Reads take one wait state so that hrdata can leave a flip-flop and still see
  // a write completed in the cycle just before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
      hreadyout <= !(accept && !hwrite);
      if (rd_pend) begin
        hrdata <= rdata;
      end
    end
  end

  always_comb begin
    flags_r = '0;
    flags_r.carry = carry;
    flags_r.bcd_err = bcd_err;
    flags_r.result = result_out;
    flags_r.div_zero = div_zero;
    flags_r.busy = div_busy;
    case (rd_addr)
      REG_OPA_LO: rdata = DATA_W'(opa[0]);
      REG_OPA_HI: rdata = DATA_W'(opa[1]);
      REG_OPB_LO: rdata = DATA_W'(opb[0]);
      REG_OPB_HI: rdata = DATA_W'(opb[1]);
      REG_RES0: rdata = DATA_W'(res[0]);
      REG_RES1: rdata = DATA_W'(res[1]);
      REG_RES2: rdata = DATA_W'(res[2]);
      REG_RES3: rdata = DATA_W'(res[3]);
      REG_FLAGS: rdata = DATA_W'(flags_r);
      REG_IRQ_STAT: rdata = DATA_W'(irq_stat);
      REG_IRQ_MASK: rdata = DATA_W'(irq_mask);
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa <= '0;
      opb <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        REG_OPA_LO: opa[0] <= hwdata[WORD_W-1:0];
        REG_OPA_HI: opa[1] <= hwdata[WORD_W-1:0];
        REG_OPB_LO: opb[0] <= hwdata[WORD_W-1:0];
        REG_OPB_HI: opb[1] <= hwdata[WORD_W-1:0];
        default: ;
      endcase
    end
  end

  assign cmd_w = bcdu_cmd_t'(hwdata[CMD_W-1:0]);
  assign flags_w = bcdu_flags_t'(hwdata[FLAGS_W-1:0]);

  assign cmd_wr = wr_pend && (wr_addr == REG_CMD);
  assign flags_wr = wr_pend && (wr_addr == REG_FLAGS);
  assign mask_wr = wr_pend && (wr_addr == REG_IRQ_MASK);
  assign stat_rd = rd_pend && (rd_addr == REG_IRQ_STAT);

  // A command written while a divide runs is dropped; software polls busy first.
  // Queuing it instead would need a second operand set, which nothing here asks for.
  assign go = cmd_wr && !div_busy;
  assign run = go && cmd_w.cond;
  assign is_sub = cmd_w.op == OP_SUB;
  assign is_as = (cmd_w.op == OP_ADD) || is_sub;
  assign is_div = cmd_w.op == OP_DIV;

  assign ok4 = bcdu_is_bcd(DATA_W'(opa[0])) && bcdu_is_bcd(DATA_W'(opb[0]));
  assign ok8 = bcdu_is_bcd(opa) && bcdu_is_bcd(opb);

  assign as_fire = run && is_as && ok4;
  assign div_start = run && is_div && ok8 && (opb != '0);
  assign bcd_fault = run && ((is_as && !ok4) || (is_div && !ok8));
  assign ins_done = (go && !div_start) || div_done;

  // Carry goes in as a carry for add and as a borrow for subtract.
  bcdu_addsub #(.DIGITS(ADD_DIGITS)) u_as (
    .a(opa[0]),
    .b(opb[0]),
    .cin(carry),
    .sub(is_sub),
    .d(as_d),
    .cout(as_c)
  );

  // A final borrow leaves the tens complement; negating it gives the magnitude.
  bcdu_addsub #(.DIGITS(ADD_DIGITS)) u_abs (
    .a(WORD_W'(0)),
    .b(as_d),
    .cin(1'b0),
    .sub(1'b1),
    .d(abs_d),
    .cout()
  );

  // The divider keeps its own copy of the operands, so they may be reloaded while it runs.
  bcdu_div #(.DIGITS(DIV_DIGITS)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(div_start),
    .dividend(opa),
    .divisor(opb),
    .busy(div_busy),
    .done(div_done),
    .quotient(quo),
    .remainder(rmd)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res <= '0;
    end else if (as_fire) begin
      res[0] <= (is_sub && as_c) ? abs_d : as_d;
    end else if (div_done) begin
      res[1:0] <= quo;
      res[3:2] <= rmd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry <= 1'b0;
    end else if (as_fire) begin
      carry <= as_c;
    end else if (flags_wr) begin
      carry <= flags_w.carry;
    end
  end

  // Writing one clears the error; a fault in the same cycle keeps it set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcd_err <= 1'b0;
    end else begin
      bcd_err <= bcd_fault || (bcd_err && !(flags_wr && flags_w.bcd_err));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_zero <= 1'b0;
    end else if (run && is_div && ok8) begin
      div_zero <= opb == '0;
    end
  end

  // Every accepted command first drops the output; only an add carry, a subtract
  // borrow or a finished divide raises it again.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_out <= 1'b0;
    end else if (go) begin
      result_out <= as_fire && as_c;
    end else if (div_done) begin
      result_out <= 1'b1;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev.done = ins_done;
    irq_ev.bcd_err = bcd_fault;
    irq_ev.result = (as_fire && as_c) || div_done;
  end

  // A read of the status register clears it, but events of that cycle survive.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else if (stat_rd) begin
      irq_stat <= irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (mask_wr) begin
      irq_mask <= bcdu_irq_t'(hwdata[IRQ_W-1:0]);
    end
  end

  // The pin comes from a flip-flop, so it trails the status by one clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : bcdu_top

// ==== dv/bcdu_asserts.sv ====
/* Port checker of the BCD arithmetic unit, bound into bcdu_top.
   Assumes one AHB-Lite master whose hready is fed from hreadyout. */
`timescale 1ns/1ps
module bcdu_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [bcdu_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [bcdu_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [bcdu_pkg::DATA_W-1:0] hrdata,
  input wire logic hresp,
  input wire logic irq,
  input wire logic result_out
);
  import bcdu_pkg::*;
  logic rd_acc;
  logic wr_acc;
  logic wr_cmd;
  logic rd_ph;
  assign rd_acc = hsel && hready && htrans[1] && !hwrite;
  assign wr_acc = hsel && hready && htrans[1] && hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cmd <= 1'b0;
      rd_ph <= 1'b0;
    end else begin
      wr_cmd <= wr_acc && haddr[7:0] == REG_CMD;
      rd_ph <= rd_acc;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_cond_off; wr_cmd && !hwdata[0] |=> !result_out; endproperty
  a_cond_off: assert property (p_cond_off)
    else $error("output on after command with condition off");
  // A divide needs at least 16 cycles; the output is checked off only for the first 6 of them.
  property p_div_quiet; wr_cmd && hwdata[2:0] == 3'b101 |=> (!result_out) [*6]; endproperty
  a_div_quiet: assert property (p_div_quiet)
    else $error("output on too early after divide start");
  property p_rd_wait; rd_acc |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read data phase not one wait state");
  property p_wr_zero; wr_acc |=> hreadyout; endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("write data phase stalled");
  property p_okay; hresp == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_rdata_hold; !$stable(hrdata) |-> $past(rd_ph); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read");
  property p_irq_clear; rd_acc && haddr[7:0] == REG_IRQ_STAT |-> ##3 !irq; endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt still high after status read");
  property p_unmapped; rd_acc && haddr[7:0] == 8'h40 |-> ##2 hrdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  c_div: cover property (wr_cmd && hwdata[2:0] == 3'b101);
  c_out: cover property ($rose(result_out));
  c_irq: cover property ($rose(irq));
endmodule : bcdu_asserts

bind bcdu_top bcdu_asserts i_bcdu_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .result_out(result_out));

// ==== dv/bcdu_seq_model.sv ====
/* Instruction sequencer model: an AHB-Lite master making single word transfers.
   Assumes hready is the slave's hreadyout and that one process calls xfer at a time. */
`timescale 1ns/1ps
module bcdu_seq_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [bcdu_pkg::DATA_W-1:0] hrdata,
  output logic hsel,
  output logic [bcdu_pkg::DATA_W-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [bcdu_pkg::DATA_W-1:0] hwdata
);
  import bcdu_pkg::*;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    // Stale write data is inverted so the slave cannot lean on it after the data phase.
    hwdata <= ~wd;
  endtask : xfer
endmodule : bcdu_seq_model

// ==== dv/bcd_arith_unit_tb_top.sv ====
/* Self-checking bench of the BCD arithmetic unit: table of add and subtract cases,
   then divide, interrupt and reset tests. Assumes the sequencer model drives the bus. */
`timescale 1ns/1ps
module bcd_arith_unit_tb_top;
  import bcdu_pkg::*;
  typedef struct packed {
    logic [2:0] cmd;
    logic [15:0] a;
    logic [15:0] b;
    logic cin;
    logic [15:0] res;
    logic c;
    logic err;
    logic out;
  } bcdu_row_t;
  localparam bcdu_row_t ROWS [9] = '{
    '{3'b001, 16'h6789, 16'h7654, 1'b0, 16'h4443, 1'b1, 1'b0, 1'b1},
    '{3'b000, 16'h1111, 16'h1111, 1'b1, 16'h4443, 1'b1, 1'b0, 1'b0},
    '{3'b001, 16'h1234, 16'h4321, 1'b1, 16'h5556, 1'b0, 1'b0, 1'b0},
    '{3'b001, 16'h9999, 16'h0000, 1'b1, 16'h0000, 1'b1, 1'b0, 1'b1},
    '{3'b011, 16'h8765, 16'h5678, 1'b1, 16'h3086, 1'b0, 1'b0, 1'b0},
    '{3'b011, 16'h0000, 16'h0001, 1'b0, 16'h0001, 1'b1, 1'b0, 1'b1},
    '{3'b010, 16'h5555, 16'h1111, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b0},
    '{3'b001, 16'h12A4, 16'h0001, 1'b0, 16'h0001, 1'b0, 1'b1, 1'b0},
    '{3'b011, 16'h0001, 16'h00F0, 1'b1, 16'h0001, 1'b1, 1'b1, 1'b0}};
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [DATA_W-1:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata;
  logic hreadyout;
  logic [DATA_W-1:0] hrdata;
  logic hresp;
  logic irq;
  logic result_out;
  logic [31:0] d;
  bcdu_flags_t f;
  int errors = 0;
  int n_compared = 0;
  bcdu_top i_bcdu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .result_out(result_out));
  bcdu_seq_model i_bcdu_seq_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] unused;
    i_bcdu_seq_model.xfer(a, 1'b1, v, unused);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    i_bcdu_seq_model.xfer(a, 1'b0, 32'h0000_0000, v);
  endtask : bus_rd
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // Polling busy is bounded; a hung divider shows up as a wrong result afterwards.
  task automatic run_div(input logic [2:0] c);
    logic [31:0] v;
    bus_wr(REG_CMD, {29'h0000_0000, c});
    for (int i = 0; i < 64; i++) begin
      bus_rd(REG_FLAGS, v);
      if (v[4] === 1'b0) break;
    end
  endtask : run_div
  task automatic stop_test();
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    repeat (40000) @(posedge hclk);
    errors++;
    stop_test();
  end
  initial begin
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_bit("result_out", 1'b0, result_out);
    chk_bit("irq", 1'b0, irq);
    bus_rd(REG_FLAGS, d);
    chk_word("flags", 32'h0000_0000, d);
    foreach (ROWS[i]) begin
      bus_wr(REG_FLAGS, {31'h0000_0001, ROWS[i].cin});
      bus_wr(REG_OPA_LO, {16'h0000, ROWS[i].a});
      bus_wr(REG_OPB_LO, {16'h0000, ROWS[i].b});
      bus_wr(REG_CMD, {29'h0000_0000, ROWS[i].cmd});
      bus_rd(REG_RES0, d);
      chk_word("res0", {16'h0000, ROWS[i].res}, d);
      bus_rd(REG_FLAGS, d);
      f = bcdu_flags_t'(d[FLAGS_W-1:0]);
      chk_bit("carry", ROWS[i].c, f.carry);
      chk_bit("bcd_err", ROWS[i].err, f.bcd_err);
      chk_bit("result_out", ROWS[i].out, result_out);
    end
    bus_wr(REG_OPA_LO, 32'h0000_7654);
    bus_wr(REG_OPA_HI, 32'h0000_0098);
    bus_wr(REG_OPB_LO, 32'h0000_0987);
    bus_wr(REG_OPB_HI, 32'h0000_0021);
    run_div(3'b101);
    bus_rd(REG_RES0, d);
    chk_word("quot_lo", 32'h0000_0004, d);
    bus_rd(REG_RES2, d);
    chk_word("rem_lo", 32'h0000_3706, d);
    bus_rd(REG_RES3, d);
    chk_word("rem_hi", 32'h0000_0014, d);
    chk_bit("result_out", 1'b1, result_out);
    run_div(3'b100);
    chk_bit("result_out", 1'b0, result_out);
    bus_wr(REG_OPA_LO, 32'h0000_9999);
    bus_wr(REG_OPA_HI, 32'h0000_9999);
    bus_wr(REG_OPB_LO, 32'h0000_0001);
    bus_wr(REG_OPB_HI, 32'h0000_0000);
    run_div(3'b101);
    bus_rd(REG_RES1, d);
    chk_word("quot_hi", 32'h0000_9999, d);
    bus_wr(REG_FLAGS, 32'h0000_0002);
    bus_wr(REG_OPA_HI, 32'h0000_00A0);
    run_div(3'b101);
    chk_bit("result_out", 1'b0, result_out);
    bus_rd(REG_FLAGS, d);
    chk_bit("bcd_err", 1'b1, d[1]);
    bus_wr(REG_OPA_HI, 32'h0000_0098);
    bus_wr(REG_OPB_LO, 32'h0000_0000);
    run_div(3'b101);
    chk_bit("result_out", 1'b0, result_out);
    bus_rd(REG_FLAGS, d);
    chk_bit("div_zero", 1'b1, d[3]);
    bus_rd(REG_RES0, d);
    chk_word("quot_lo", 32'h0000_9999, d);
    bus_rd(REG_IRQ_STAT, d);
    bus_wr(REG_IRQ_MASK, 32'h0000_0000);
    bus_wr(REG_CMD, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk_bit("irq", 1'b0, irq);
    bus_wr(REG_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    chk_bit("irq", 1'b1, irq);
    bus_rd(REG_IRQ_STAT, d);
    chk_word("irq_stat", 32'h0000_0001, d);
    repeat (3) @(posedge hclk);
    chk_bit("irq", 1'b0, irq);
    bus_rd(8'h40, d);
    chk_word("unmapped", 32'h0000_0000, d);
    // Overflowing add seen in the status, then the no-op code drops the output.
    bus_wr(REG_OPB_LO, 32'h0000_0001);
    bus_wr(REG_CMD, 32'h0000_0001);
    bus_rd(REG_IRQ_STAT, d);
    chk_word("irq_stat", 32'h0000_0005, d);
    chk_bit("result_out", 1'b1, result_out);
    bus_wr(REG_CMD, 32'h0000_0007);
    bus_rd(REG_FLAGS, d);
    chk_word("flags", 32'h0000_000B, d);
    // An add written while the divider runs must be dropped and leave carry alone.
    bus_wr(REG_FLAGS, 32'h0000_0002);
    bus_wr(REG_CMD, 32'h0000_0005);
    run_div(3'b001);
    bus_rd(REG_FLAGS, d);
    chk_word("flags", 32'h0000_0004, d);
    bus_rd(REG_RES1, d);
    chk_word("quot_hi", 32'h0000_0098, d);
    // Reset in the middle of a divide returns every output and flag to idle.
    bus_wr(REG_CMD, 32'h0000_0005);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_rd(REG_FLAGS, d);
    chk_word("flags", 32'h0000_0000, d);
    chk_bit("result_out", 1'b0, result_out);
    chk_bit("irq", 1'b0, irq);
    stop_test();
  end
endmodule : bcd_arith_unit_tb_top
